// >>> rtl/fftcf_core.sv
`timescale 1ns/10ps
`default_nettype none
module fftcf_core
   import fftcf_pkg::*;
(
   // Clock, reset and clock enable.
   input  wire logic            hclk,
   input  wire logic            hresetn,
   input  wire logic            ce,
   // AHB-Lite slave.
   input  wire logic            hsel,
   input  wire logic [31:0]     haddr,
   input  wire logic [1:0]      htrans,
   input  wire logic            hwrite,
   input  wire logic [2:0]      hsize,
   input  wire logic [31:0]     hwdata,
   input  wire logic            hready,
   output logic                 hreadyout,
   output logic                 hresp,
   output logic [31:0]          hrdata,
   // Input block stream.
   input  wire fftcf_smp_t      din,
   input  wire logic            ibstart,
   output logic                 rfib,
   output logic                 ibend,
   // Output block stream.
   output fftcf_smp_t           dout,
   output logic                 obstart,
   output logic                 outvalid,
   output logic                 except,
   output logic [EXPW-1:0]      exponent
);

   fftcf_state_t     state;
   fftcf_state_t     next_state;
   fftcf_cfg_t       pend;
   fftcf_cfg_t       active;
   fftcf_cfg_t       next_cfg;
   fftcf_cfg_t       cfg_use;
   fftcf_smp_t       scaled;
   logic             ovf;
   logic             wr_pend;
   logic [7:0]       wr_ofs;
   logic             do_wr;
   logic             mode_set;
   logic             sfact_set;
   logic             point_set;
   logic             start_ok;
   logic [AW-1:0]    cnt;
   logic [AW-1:0]    blk_last;
   logic [EXPW-1:0]  shift;
   logic             blk_ovf;
   logic             out_ovf;
   logic             last_except;
   logic [EXPW-1:0]  out_exp;
   logic [31:0]      next_rdata;
   logic [2*DW-1:0]  mem [NMAX];

   // Bus slave: zero wait states, stalled only while the clock enable is low.
   assign hreadyout = ce;
   assign hresp     = HRESP_OKAY;
   assign do_wr     = wr_pend & ce;
   assign mode_set  = do_wr && (wr_ofs == OFS_MODE);
   assign sfact_set = do_wr && (wr_ofs == OFS_SFACT);
   assign point_set = do_wr && (wr_ofs == OFS_POINTS);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_ofs  <= 8'h00;
      end else if (ce && hready) begin
         wr_pend <= hsel && htrans[1] && hwrite;
         wr_ofs  <= haddr[7:0];
      end
   end

   always_comb begin
      next_rdata = 32'h00000000;
      case (haddr[7:0])
         OFS_MODE:   next_rdata[0] = pend.mode;
         OFS_SFACT:  next_rdata[SFW-1:0] = pend.sfact;
         OFS_POINTS: next_rdata[PW-1:0] = pend.points;
         OFS_STATUS: begin
            next_rdata[STB_RFIB]                     = rfib;
            next_rdata[STB_READ]                     = (state == ST_READ);
            next_rdata[STB_OUT]                      = (state == ST_OUT);
            next_rdata[STB_EXCEPT]                   = last_except;
            next_rdata[STB_EXP_LSB+EXPW-1:STB_EXP_LSB] = out_exp;
         end
         default:    next_rdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (ce && hready && hsel && htrans[1] && !hwrite) begin
         hrdata <= next_rdata;
      end
   end

   // Loaded configuration, waiting for the next accepted block start.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend.mode   <= MODE_RST;
         pend.sfact  <= SFACT_RST;
         pend.points <= POINTS_RST;
      end else if (ce) begin
         if (mode_set) begin
            pend.mode <= hwdata[0];
         end
         if (sfact_set) begin
            pend.sfact <= hwdata[SFW-1:0];
         end
         if (point_set) begin
            pend.points <= fftcf_clamp(hwdata[PW-1:0]);
         end
      end
   end

   // A load in the same cycle as the start already counts for that block.
   always_comb begin
      next_cfg = pend;
      if (mode_set) begin
         next_cfg.mode = hwdata[0];
      end
      if (sfact_set) begin
         next_cfg.sfact = hwdata[SFW-1:0];
      end
      if (point_set) begin
         next_cfg.points = fftcf_clamp(hwdata[PW-1:0]);
      end
   end

   assign start_ok = ibstart && (state == ST_IDLE);
   assign cfg_use  = (state == ST_IDLE) ? next_cfg : active;
   assign shift    = fftcf_total_shift(cfg_use.sfact, cfg_use.points);
   assign blk_last = AW'((15'h0001 << active.points) - 15'h0001);

   fftcf_scaler u_scaler (
      .din     (din),
      .points  (cfg_use.points),
      .shift   (shift),
      .inverse (cfg_use.mode),
      .dout    (scaled),
      .ovf     (ovf)
   );

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: if (start_ok) begin
            next_state = ST_READ;
         end
         ST_READ: if (cnt == blk_last) begin
            next_state = ST_OUT;
         end
         ST_OUT:  if (cnt == blk_last) begin
            next_state = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= ST_IDLE;
         rfib  <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         rfib  <= (next_state == ST_IDLE);
      end
   end

   // Sample counter: the start cycle carries sample 0, the rest follow gapless.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= '0;
      end else if (ce) begin
         if (start_ok) begin
            cnt <= 14'h0001;
         end else if (state != ST_IDLE) begin
            cnt <= (cnt == blk_last) ? 14'h0000 : cnt + 14'h0001;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         active.mode   <= MODE_RST;
         active.sfact  <= SFACT_RST;
         active.points <= POINTS_RST;
      end else if (ce && start_ok) begin
         active <= next_cfg;
      end
   end

   assign ibend = (state == ST_READ) && (cnt == blk_last);

   always_ff @(posedge hclk) begin
      if (ce && (start_ok || (state == ST_READ))) begin
         mem[start_ok ? 14'h0000 : cnt] <= scaled;
      end
   end

   // Overflow and exponent travel with the block to its output phase.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         blk_ovf     <= 1'b0;
         out_ovf     <= 1'b0;
         out_exp     <= '0;
         last_except <= 1'b0;
      end else if (ce) begin
         if (start_ok) begin
            blk_ovf <= ovf;
         end else if (state == ST_READ) begin
            blk_ovf <= blk_ovf | ovf;
         end
         if (ibend) begin
            out_ovf     <= blk_ovf | ovf;
            last_except <= blk_ovf | ovf;
            out_exp     <= shift;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dout     <= '0;
         obstart  <= 1'b0;
         outvalid <= 1'b0;
         except   <= 1'b0;
         exponent <= '0;
      end else if (ce) begin
         dout     <= (state == ST_OUT) ? mem[cnt] : '0;
         obstart  <= (state == ST_OUT) && (cnt == 14'h0000);
         outvalid <= (state == ST_OUT);
         except   <= (state == ST_OUT) && out_ovf;
         if ((state == ST_OUT) && (cnt == 14'h0000)) begin
            exponent <= out_exp;
         end
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn || !ce);

   a_rfib_drop:    assert property (ibstart && rfib |=> !rfib)
      else $error("ready stayed high after an accepted start");
   a_start_ignore: assert property (state == ST_READ && ibstart && !ibend |=> state == ST_READ && cnt == $past(cnt) + 14'h0001)
      else $error("start during an input block disturbed the read");
   a_read_gapless: assert property (start_ok |=> (state == ST_READ && !rfib)[*8])
      else $error("input read sequence had a gap");
   a_ibend_single: assert property (ibend |=> !ibend ##1 !ibend)
      else $error("input end was not a single pulse");
   a_points_range: assert property (active.points >= PTS_MIN && active.points <= PTS_MAX)
      else $error("active point count out of range");
   a_mode_capture: assert property (start_ok && mode_set |=> active.mode == $past(hwdata[0]))
      else $error("direction loaded with the start was not applied");
   a_sfact_capture: assert property (start_ok && sfact_set |=> active.sfact == $past(hwdata[SFW-1:0]))
      else $error("scaling loaded with the start was not applied");
   a_obstart_pulse: assert property ($rose(outvalid) |-> obstart ##1 (outvalid && !obstart)[*7])
      else $error("output start did not mark the block head");
   a_outvalid_run: assert property (obstart |-> outvalid[*8])
      else $error("output valid dropped inside a block");
   a_except_valid: assert property (except |-> outvalid)
      else $error("exception shown outside a valid output");
   a_ready_after_end: assert property (state == ST_OUT && cnt == blk_last |=> rfib)
      else $error("ready did not rise after the output block");

   c_start:   cover property (start_ok);
   c_ignored: cover property (state == ST_READ && ibstart);
   c_output:  cover property (obstart);
   c_except:  cover property (except);

endmodule // fftcf_core
`default_nettype wire

// >>> rtl/fftcf_pkg.sv
package fftcf_pkg;

   // Sample, configuration and exponent widths.
   localparam int DW         = 16;
   localparam int SFW        = 28;
   localparam int PW         = 4;
   localparam int EXPW       = 15;
   localparam int AW         = 14;
   localparam int NMAX       = 16384;
   localparam int MAX_STAGES = 14;

   // Point-count limits, as the base-two logarithm of the length.
   localparam logic [PW-1:0] PTS_MIN = 4'h6;
   localparam logic [PW-1:0] PTS_MAX = 4'he;

   // Register byte offsets.
   localparam logic [7:0] OFS_MODE   = 8'h00;
   localparam logic [7:0] OFS_SFACT  = 8'h04;
   localparam logic [7:0] OFS_POINTS = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;

   // Status register field positions.
   localparam int STB_RFIB    = 0;
   localparam int STB_READ    = 1;
   localparam int STB_OUT     = 2;
   localparam int STB_EXCEPT  = 3;
   localparam int STB_EXP_LSB = 16;

   // Reset values of the configuration registers.
   localparam logic           MODE_RST   = 1'b0;
   localparam logic [SFW-1:0] SFACT_RST  = 28'h0000000;
   localparam logic [PW-1:0]  POINTS_RST = 4'h6;

   // Bus response codes.
   localparam logic HRESP_OKAY = 1'b0;

   typedef struct packed {
      logic           mode;
      logic [SFW-1:0] sfact;
      logic [PW-1:0]  points;
   } fftcf_cfg_t;

   typedef struct packed {
      logic signed [DW-1:0] re;
      logic signed [DW-1:0] im;
   } fftcf_smp_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_READ = 2'b01,
      ST_OUT  = 2'b10
   } fftcf_state_t;

   // Forces a point-count code into the legal range.
   function automatic logic [PW-1:0] fftcf_clamp(input logic [PW-1:0] pts);
      if (pts < PTS_MIN) begin
         return PTS_MIN;
      end else if (pts > PTS_MAX) begin
         return PTS_MAX;
      end
      return pts;
   endfunction

   // Sums the stage shifts; stage 1 owns the top bit pair.
   function automatic logic [EXPW-1:0] fftcf_total_shift(input logic [SFW-1:0] sf, input logic [PW-1:0] pts);
      logic [EXPW-1:0] sum;
      logic [1:0]      fld;
      sum = '0;
      for (int i = 0; i < MAX_STAGES; i++) begin
         fld = sf[SFW-1-2*i -: 2];
         if ((i == int'(pts) - 1) && pts[0]) begin
            fld[1] = 1'b0;
         end
         if (i < int'(pts)) begin
            sum = sum + EXPW'(fld);
         end
      end
      return sum;
   endfunction

endpackage

// >>> rtl/fftcf_scaler.sv
`timescale 1ns/10ps
`default_nettype none
module fftcf_scaler
   import fftcf_pkg::*;
(
   // Sample in and its configuration.
   input  wire fftcf_smp_t      din,
   input  wire logic [PW-1:0]   points,
   input  wire logic [EXPW-1:0] shift,
   input  wire logic            inverse,
   // Scaled sample out.
   output fftcf_smp_t           dout,
   output logic                 ovf
);

   logic signed [7:0]  gain;
   logic signed [DW:0] im_in;
   logic [DW:0]        re_res;
   logic [DW:0]        im_res;

   // Applies a signed gain of two to the power g, saturating on overflow.
   function automatic logic [DW:0] scale(input logic signed [DW:0] x, input logic signed [7:0] g);
      logic signed [47:0] w;
      logic signed [7:0]  ng;
      w  = 48'(x);
      ng = -g;
      if (g >= 0) begin
         w = w <<< g[4:0];
      end else begin
         w = w >>> ng[5:0];
      end
      if (w > 48'sh0000_0000_7fff) begin
         return {1'b1, 16'h7fff};
      end else if (w < $signed(48'hffff_ffff_8000)) begin
         return {1'b1, 16'h8000};
      end
      return {1'b0, w[DW-1:0]};
   endfunction

   // Each stage may double the magnitude and shifts right by its own field.
   assign gain   = $signed({4'h0, points}) - $signed({1'b0, shift[6:0]});
   // The inverse transform works on the conjugate.
   assign im_in  = inverse ? -$signed({din.im[DW-1], din.im}) : $signed({din.im[DW-1], din.im});
   assign re_res = scale($signed({din.re[DW-1], din.re}), gain);
   assign im_res = scale(im_in, gain);

   assign dout.re = re_res[DW-1:0];
   assign dout.im = im_res[DW-1:0];
   assign ovf     = re_res[DW] | im_res[DW];

endmodule // fftcf_scaler
`default_nettype wire

// >>> testbench/fft_block_config_handshake_bench.sv
`timescale 1ns/10ps
`default_nettype none
module fft_block_config_handshake_bench
   import fftcf_pkg::*;
;
   typedef struct {logic [31:0] a; logic [31:0] wd; logic [31:0] rd;} fftcf_row_t;
   logic            hclk, hresetn, hsel, hwrite, go, extra, hreadyout, hresp;
   logic            rfib, ibend, ibstart, obstart, outvalid, except, pv_start, e_mode, e_ovf;
   logic [1:0]      htrans;
   logic [31:0]     haddr, hwdata, hrdata, rd;
   logic [PW-1:0]   npts, e_pts;
   logic [EXPW-1:0] exponent, e_exp;
   fftcf_smp_t      din, dout;
   fftcf_row_t      rows[9];
   int              n_fail, total_checks, cyc, ib_cyc, st_cyc, ocnt, nblk;

   fftcf_core fftcf_core_i (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .din(din), .ibstart(ibstart), .rfib(rfib),
      .ibend(ibend), .dout(dout), .obstart(obstart), .outvalid(outvalid), .except(except), .exponent(exponent));
   fftcf_source fftcf_source_i (.hclk(hclk), .hresetn(hresetn), .go(go), .extra(extra), .npts(npts),
      .rfib(rfib), .din(din), .ibstart(ibstart));

   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task print_verdict;
      if (n_fail == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic wait_ready;
      int i;
      i = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         i++;
         if (i > 50) begin n_fail++; print_verdict; end
         @(posedge hclk);
      end
   endtask

   // One single AHB transfer; read data is taken at the closing edge.
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= wr;
      wait_ready;
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_ready;
      d = hrdata;
   endtask

   task automatic wait_rfib(input logic lvl);
      int i;
      for (i = 0; rfib !== lvl; i++) begin
         if (i > 3000) begin n_fail++; print_verdict; end
         @(negedge hclk);
      end
   endtask

   task automatic cfg(input logic [31:0] p, input logic [31:0] sf, input logic m, input int ex, input logic ov);
      ahb(1'b1, 32'h08, p, rd);
      ahb(1'b1, 32'h04, sf, rd);
      ahb(1'b1, 32'h00, 32'(m), rd);
      npts  <= p[PW-1:0];
      e_pts = p[PW-1:0];
      e_exp = EXPW'(ex);
      e_mode = m;
      e_ovf = ov;
   endtask

   task automatic run_block(input logic xs, input logic late_mode);
      @(posedge hclk);
      go    <= 1'b1;
      extra <= xs;
      wait_rfib(1'b0);
      @(posedge hclk);
      go    <= 1'b0;
      if (late_mode) ahb(1'b1, 32'h00, 32'h1, rd);
      wait_rfib(1'b1);
   endtask

   // Forward passes the sample; inverse negates the imaginary part.
   function automatic logic [31:0] expd(input int k);
      logic [15:0] r;
      r = 16'(k) * 16'h0101;
      return {r, e_mode ? r + 16'h1 : ~r};
   endfunction

   always @(negedge hclk) begin
      if (hresetn === 1'b1) begin
         cyc++;
         if (pv_start) check("rfib_fall", 32'(rfib), 32'h0);
         pv_start = ibstart && rfib;
         if (pv_start) st_cyc = cyc;
         if (ibend === 1'b1) begin
            ib_cyc = cyc;
            check("ibend_at", cyc - st_cyc, (1 << e_pts) - 1);
         end
         if (outvalid === 1'b1) begin
            if (ocnt == 0) begin
               check("obstart_at", cyc, ib_cyc + 2);
               check("exponent", 32'(exponent), 32'(e_exp));
               nblk++;
            end
            check("obstart", 32'(obstart), 32'(ocnt == 0));
            check("except", 32'(except), 32'(e_ovf));
            if (!e_ovf) check("dout", dout, expd(ocnt));
            ocnt++;
         end else if (ocnt != 0) begin
            check("out_len", ocnt, 1 << e_pts);
            ocnt = 0;
         end
      end
   end

   initial begin
      hresetn = 1'b0;
      {hsel, hwrite, go, extra, pv_start, e_mode, e_ovf} = '0;
      htrans = 2'b00;
      haddr = '0;
      hwdata = '0;
      npts = 4'h6;
      e_pts = 4'h6;
      e_exp = '0;
      {n_fail, total_checks, cyc, ib_cyc, st_cyc, ocnt, nblk} = '0;
      rows = '{'{32'h08, 32'h0, 32'h6}, '{32'h08, 32'h5, 32'h6}, '{32'h08, 32'h6, 32'h6},
               '{32'h08, 32'h9, 32'h9}, '{32'h08, 32'he, 32'he}, '{32'h08, 32'hf, 32'he},
               '{32'h00, 32'h3, 32'h1}, '{32'h04, 32'hffffffff, 32'h0fffffff}, '{32'h10, 32'h1, 32'h0}};
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (rows[i]) begin
         ahb(1'b1, rows[i].a, rows[i].wd, rd);
         ahb(1'b0, rows[i].a, 32'h0, rd);
         check("reg", rd, rows[i].rd);
      end
      // Extra start inside the block, and a mode write that waits for the next block.
      cfg(32'h6, 32'h05550000, 1'b0, 6, 1'b0);
      run_block(1'b1, 1'b1);
      check("blocks", nblk, 1);
      // Odd point code: the last field counts only its low bit.
      npts <= 4'h7;
      ahb(1'b1, 32'h08, 32'h7, rd);
      ahb(1'b1, 32'h04, 32'h0555c000, rd);
      {e_pts, e_exp, e_mode} = {4'h7, 15'h7, 1'b1};
      run_block(1'b0, 1'b0);
      check("blocks", nblk, 2);
      // Scaling cleared in the start cycle itself leaves no shift, so the block saturates.
      cfg(32'h6, 32'h0fffffff, 1'b0, 0, 1'b1);
      fork
         run_block(1'b0, 1'b0);
         ahb(1'b1, 32'h04, 32'h0, rd);
      join
      check("blocks", nblk, 3);
      // Second reset once the third block has ended and the core is idle.
      @(posedge hclk);
      hresetn <= 1'b0;
      @(negedge hclk);
      check("rst_ctl", 32'({rfib, ibend, obstart, outvalid, except, exponent}), 32'h0);
      check("rst_dout", dout, 32'h0);
      @(posedge hclk);
      hresetn <= 1'b1;
      wait_rfib(1'b1);
      ahb(1'b0, 32'h00, 32'h0, rd);
      check("mode_rst", rd, 32'(MODE_RST));
      ahb(1'b0, 32'h04, 32'h0, rd);
      check("sfact_rst", rd, 32'(SFACT_RST));
      ahb(1'b0, 32'h08, 32'h0, rd);
      check("points_rst", rd, 32'(POINTS_RST));
      ahb(1'b0, 32'h0c, 32'h0, rd);
      check("status_rfib", 32'(rd[STB_RFIB]), 32'h1);
      print_verdict;
   end
endmodule // fft_block_config_handshake_bench
`default_nettype wire

// >>> testbench/fftcf_source.sv
`timescale 1ns/10ps
`default_nettype none
// Upstream source: one block per go request, started while ready is high; the extra mid-block start pulse ignores ready.
module fftcf_source
   import fftcf_pkg::*;
(
   // Clock and reset.
   input  wire logic          hclk,
   input  wire logic          hresetn,
   // Control from the bench.
   input  wire logic          go,
   input  wire logic          extra,
   input  wire logic [PW-1:0] npts,
   // Stream towards the core.
   input  wire logic          rfib,
   output fftcf_smp_t         din,
   output logic               ibstart
);
   logic        act;
   logic [14:0] cnt;
   logic [15:0] nval;

   assign nval = 16'(cnt + 15'h1) * 16'h0101;

   // The bench loads the point count before go, so it precedes the start.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         act     <= 1'b0;
         cnt     <= '0;
         ibstart <= 1'b0;
         din     <= '0;
      end else begin
         ibstart <= 1'b0;
         if (!act && go && rfib) begin
            ibstart <= 1'b1;
            act     <= 1'b1;
            cnt     <= '0;
            din     <= '{re: 16'h0000, im: 16'hffff};
         end else if (act && cnt != (15'h1 << npts) - 15'h1) begin
            cnt     <= cnt + 15'h1;
            din     <= '{re: nval, im: ~nval};
            ibstart <= extra && cnt == 15'h9;
         end else begin
            act <= 1'b0;
            din <= '{re: ~din.re, im: ~din.im};
         end
      end
   end
endmodule // fftcf_source
`default_nettype wire
